// [include/pwr_pkg.sv]
// Shared constants and types for the power-down and wake control block.
`default_nettype none
package pwr_pkg;
	// Bus geometry and answers.
	localparam int          ADDR_W         = 12;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// Power control register: direct address kept as index, byte address is four times it.
	localparam logic [7:0]  POWER_CONTROL_INDEX = 8'h87;
	localparam logic [11:0] POWER_CONTROL_ADDR  = {2'h0, POWER_CONTROL_INDEX, 2'h0};
	localparam logic [11:0] INT_STATUS_ADDR     = 12'h000;
	localparam logic [11:0] INT_ENABLE_ADDR     = 12'h004;
	localparam logic [11:0] INT_CLEAR_ADDR      = 12'h008;
	localparam logic [11:0] MODE_STATUS_ADDR    = 12'h00C;
	// Power control field positions.
	localparam int SLEEP_BIT  = 0;
	localparam int PD_BIT     = 1;
	localparam int UF0_BIT    = 2;
	localparam int UF1_BIT    = 3;
	localparam int COLD_BIT   = 4;
	localparam int FRAME_BIT  = 6;
	localparam int BAUD_BIT   = 7;
	localparam logic [7:0] POWER_CONTROL_COLD_RESET = 8'h10;
	localparam logic [7:0] POWER_CONTROL_WRITE_MASK = 8'hDF;
	// Event bits of the interrupt status, enable and clear registers.
	localparam int EVENT_W     = 4;
	localparam int EV_PD_ENTER = 0;
	localparam int EV_IRQ_WAKE = 1;
	localparam int EV_RST_WAKE = 2;
	localparam int EV_IDLE_END = 3;
	// Pin filter depth.
	localparam int SYNC_STAGES = 3;
	typedef enum logic [2:0] {
		MODE_RUN, MODE_IDLE, MODE_STOPPED, MODE_WAKING, MODE_VECTOR
	} mode_t;
endpackage
`default_nettype wire

// [include/wake_if.sv]
// Filtered wake levels passed from the pin filter to the controller.
`default_nettype none
interface wake_if;
	logic [1:0] irq_low;
	logic       rst_level;
	modport producer (output irq_low, output rst_level);
	modport consumer (input irq_low, input rst_level);
endinterface
`default_nettype wire

// [hdl/wake_pin_filter.sv]
// Three-stage pin filter for the reset and external interrupt wake lines.
`default_nettype none
module wake_pin_filter #(
	parameter int WIDTH  = 3,
	parameter int STAGES = pwr_pkg::SYNC_STAGES
) (
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Raw active-high pin levels.
	input  wire logic [WIDTH-1:0] pin_active,
	// Filtered levels.
	wake_if.producer              wake
);
	import pwr_pkg::*;

	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] level_ff;
	logic [WIDTH-1:0] nxt_level;

	if (WIDTH != 3 || STAGES != 3) begin : g_check
		$error("wake_pin_filter serves three pins through three stages only");
	end

	// A change counts only once the second and third stages agree.
	assign nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s1_ff    <= 3'h0;
			s2_ff    <= 3'h0;
			s3_ff    <= 3'h0;
			level_ff <= 3'h0;
		end else begin
			s1_ff    <= pin_active;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	assign wake.irq_low   = level_ff[1:0];
	assign wake.rst_level = level_ff[2];
endmodule
`default_nettype wire

// [hdl/power_down_wake_control.sv]
// Power-down, idle and wake control with its AXI4-Lite register slave.
// How it works
// - Writing one to bit 1 of the power control register puts the device into power-down.
// - In power-down the oscillator halts and the core gets no further clock until wake-up.
// - Idle drives both strobes high, power-down drives them low, port 0 floats and port 2 addresses as tabled.
// - Power-down ends only by reset or a level-sensitive external interrupt zero or one.
// - An interrupt wakes only if enabled and above the priority of any interrupt in service.
// - The core clock returns only after the wake level ends; the outside holds it until the oscillator is stable.
// - An interrupt wake ends power-down when the core takes its forced jump to the service routine.
// - That interrupt exit clears the power-down bit so a later entry works.
// - After the service routine returns the core resumes after the entering instruction.
// - An external reset clears the power-down bit and all other power control bits except the cold start flag but leaves RAM alone.
// - The cold start flag in bit 4 is set by hardware on power-on.
// - Only power loss or a software write changes the cold start flag.
// - Bit 0 stops the core in idle; an enabled interrupt or a hardware reset clears it.
`default_nettype none
module power_down_wake_control (
	// Clock and power-on reset.
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	// AXI4-Lite write channels.
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [pwr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	// AXI4-Lite read channels.
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [pwr_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// Core side.
	input  wire logic                      core_ale,
	input  wire logic                      core_fetch_strobe,
	input  wire logic                      ext_prog_mem,
	input  wire logic [1:0]                irq_enable,
	input  wire logic [1:0]                irq_level_mode,
	input  wire logic [3:0]                irq_prio,
	input  wire logic                      isr_active,
	input  wire logic [1:0]                isr_prio,
	input  wire logic                      irq_taken,
	input  wire logic                      vector_ack,
	// Wake pins.
	input  wire logic                      ext_irq_zero_n,
	input  wire logic                      ext_irq_one_n,
	input  wire logic                      reset_pin,
	// Clock and reset control.
	output logic                           osc_enable,
	output logic                           core_clk_en,
	output logic                           warm_reset,
	output logic                           wake_vector_req,
	output logic                           wake_vector_sel,
	// Pin control.
	output logic                           ale_out,
	output logic                           program_fetch_strobe,
	output logic                           port0_float,
	output logic                           port2_addr_sel,
	// Serial configuration and interrupt.
	output logic                           baud_double_select,
	output logic                           framing_error_select,
	output logic                           irq
);
	import pwr_pkg::*;

	wake_if wake ();

	logic [11:0]        awaddr_ff;
	logic [31:0]        wdata_ff;
	logic               wstrb0_ff;
	logic               aw_got_ff;
	logic               w_got_ff;
	logic               awready_ff;
	logic               wready_ff;
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;
	logic               arready_ff;
	logic               rvalid_ff;
	logic [31:0]        rdata_ff;
	logic [1:0]         rresp_ff;
	logic [7:0]         power_control_ff;
	logic [7:0]         nxt_power_control;
	mode_t              mode_ff;
	mode_t              nxt_mode;
	logic               src_rst_ff;
	logic               nxt_src_rst;
	logic               src_irq_ff;
	logic               nxt_src_irq;
	logic [EVENT_W-1:0] status_ff;
	logic [EVENT_W-1:0] enable_ff;
	logic [EVENT_W-1:0] events;
	logic [EVENT_W-1:0] clr_bits;
	logic [EVENT_W-1:0] nxt_status;
	logic               osc_ff;
	logic               clk_en_ff;
	logic               warm_ff;
	logic               vreq_ff;
	logic               vsel_ff;
	logic               ale_ff;
	logic               fetch_ff;
	logic               p0_float_ff;
	logic               p2_addr_ff;
	logic               irq_ff;

	wake_pin_filter #(.WIDTH(3), .STAGES(SYNC_STAGES)) u_filter (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.pin_active ({reset_pin, ~ext_irq_one_n, ~ext_irq_zero_n}),
		.wake       (wake.producer)
	);

	function automatic logic is_mapped(input logic [11:0] a);
		logic [11:0] w;
		w = {a[11:2], 2'h0};
		return w == POWER_CONTROL_ADDR || w == INT_STATUS_ADDR || w == INT_ENABLE_ADDR ||
			w == INT_CLEAR_ADDR || w == MODE_STATUS_ADDR;
	endfunction

	function automatic logic may_wake(input logic en, input logic lvl,
		input logic [1:0] prio, input logic act, input logic [1:0] act_prio);
		return en && lvl && (!act || prio > act_prio);
	endfunction

	// Write path: address and data are taken in either order, then applied together.
	wire        aw_hs    = s_axi_awvalid && awready_ff;
	wire        w_hs     = s_axi_wvalid && wready_ff;
	wire        wr_fire  = aw_got_ff && w_got_ff && !bvalid_ff;
	wire [11:0] wr_word  = {awaddr_ff[11:2], 2'h0};
	wire        wr_ok    = is_mapped(awaddr_ff);
	wire        wr_power_control  = wr_fire && wr_word == POWER_CONTROL_ADDR && wstrb0_ff;
	wire        wr_en    = wr_fire && wr_word == INT_ENABLE_ADDR && wstrb0_ff;
	wire        wr_clr   = wr_fire && wr_word == INT_CLEAR_ADDR && wstrb0_ff;
	wire        nxt_awg  = (aw_got_ff || aw_hs) && !wr_fire;
	wire        nxt_wg   = (w_got_ff || w_hs) && !wr_fire;
	wire        nxt_bv   = wr_fire || (bvalid_ff && !s_axi_bready);
	// Read path.
	wire        ar_hs    = s_axi_arvalid && arready_ff;
	wire        nxt_rv   = ar_hs || (rvalid_ff && !s_axi_rready);
	wire [11:0] rd_word  = {s_axi_araddr[11:2], 2'h0};
	wire [31:0] rd_data  =
		rd_word == POWER_CONTROL_ADDR ? {24'h000000, power_control_ff} :
		rd_word == INT_STATUS_ADDR    ? {28'h0000000, status_ff} :
		rd_word == INT_ENABLE_ADDR    ? {28'h0000000, enable_ff} :
		rd_word == MODE_STATUS_ADDR   ? {27'h0000000, src_irq_ff, src_rst_ff, 3'(mode_ff)} :
		32'h00000000;

	// Wake qualification per interrupt line.
	wire q0 = may_wake(irq_enable[0], irq_level_mode[0], irq_prio[1:0], isr_active, isr_prio);
	wire q1 = may_wake(irq_enable[1], irq_level_mode[1], irq_prio[3:2], isr_active, isr_prio);
	wire w0 = q0 && wake.irq_low[0];
	wire w1 = q1 && wake.irq_low[1];
	wire rst_lv   = wake.rst_level;
	wire src_line = src_irq_ff ? wake.irq_low[1] : wake.irq_low[0];

	always_comb begin
		nxt_power_control    = power_control_ff;
		nxt_mode    = mode_ff;
		nxt_src_rst = src_rst_ff;
		nxt_src_irq = src_irq_ff;
		if (wr_power_control) begin
			nxt_power_control = wdata_ff[7:0] & POWER_CONTROL_WRITE_MASK;
		end
		case (mode_ff)
			MODE_RUN: begin
				if (nxt_power_control[PD_BIT]) begin
					nxt_mode = MODE_STOPPED;
				end else if (nxt_power_control[SLEEP_BIT]) begin
					nxt_mode = MODE_IDLE;
				end
			end
			MODE_IDLE: begin
				if (irq_taken) begin
					nxt_power_control[SLEEP_BIT] = 1'b0;
				end
				if (!nxt_power_control[SLEEP_BIT]) begin
					nxt_mode = MODE_RUN;
				end
			end
			MODE_STOPPED: begin
				// Only the reset line or a qualified interrupt level can leave this state.
				if (rst_lv) begin
					nxt_mode    = MODE_WAKING;
					nxt_src_rst = 1'b1;
				end else if (w0 || w1) begin
					nxt_mode    = MODE_WAKING;
					nxt_src_rst = 1'b0;
					nxt_src_irq = !w0;
				end
			end
			MODE_WAKING: begin
				// The oscillator runs but the core waits for the wake level to end.
				if (src_rst_ff && !rst_lv) begin
					nxt_mode = MODE_RUN;
				end else if (!src_rst_ff && !src_line) begin
					nxt_mode = MODE_VECTOR;
				end
			end
			MODE_VECTOR: begin
				if (vector_ack) begin
					nxt_mode           = MODE_RUN;
					nxt_power_control[PD_BIT]   = 1'b0;
				end
			end
			default: begin
				nxt_mode = MODE_RUN;
			end
		endcase
		// A reset line level re-initialises the register but never the cold start flag.
		if (rst_lv) begin
			nxt_power_control = {3'h0, power_control_ff[COLD_BIT], 4'h0};
			if (mode_ff != MODE_STOPPED && mode_ff != MODE_WAKING) begin
				nxt_mode = MODE_RUN;
			end
		end
	end

	assign events[EV_PD_ENTER] = mode_ff == MODE_RUN && nxt_mode == MODE_STOPPED;
	assign events[EV_IRQ_WAKE] = mode_ff == MODE_VECTOR && nxt_mode == MODE_RUN;
	assign events[EV_RST_WAKE] = mode_ff == MODE_WAKING && nxt_mode == MODE_RUN;
	assign events[EV_IDLE_END] = mode_ff == MODE_IDLE && nxt_mode == MODE_RUN;
	assign clr_bits   = wr_clr ? wdata_ff[EVENT_W-1:0] : 4'h0;
	// A new event in the clearing cycle stays set.
	assign nxt_status = (status_ff & ~clr_bits) | events;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			awaddr_ff  <= 12'h000;
			wdata_ff   <= 32'h00000000;
			wstrb0_ff  <= 1'b0;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= RESP_OKAY;
		end else begin
			if (aw_hs) awaddr_ff <= s_axi_awaddr;
			if (w_hs) begin
				wdata_ff  <= s_axi_wdata;
				wstrb0_ff <= s_axi_wstrb[0];
			end
			aw_got_ff  <= nxt_awg;
			w_got_ff   <= nxt_wg;
			awready_ff <= !nxt_awg;
			wready_ff  <= !nxt_wg;
			bvalid_ff  <= nxt_bv;
			if (wr_fire) bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			arready_ff <= !nxt_rv;
			rvalid_ff  <= nxt_rv;
			if (ar_hs) begin
				rdata_ff <= rd_data;
				rresp_ff <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			power_control_ff    <= POWER_CONTROL_COLD_RESET;
			mode_ff    <= MODE_RUN;
			src_rst_ff <= 1'b0;
			src_irq_ff <= 1'b0;
			status_ff  <= 4'h0;
			enable_ff  <= 4'h0;
			irq_ff     <= 1'b0;
		end else begin
			power_control_ff    <= nxt_power_control;
			mode_ff    <= nxt_mode;
			src_rst_ff <= nxt_src_rst;
			src_irq_ff <= nxt_src_irq;
			status_ff  <= nxt_status;
			if (wr_en) enable_ff <= wdata_ff[EVENT_W-1:0];
			irq_ff     <= |(nxt_status & (wr_en ? wdata_ff[EVENT_W-1:0] : enable_ff));
		end
	end

	// Pin and clock outputs follow the next mode so they change with it.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			osc_ff      <= 1'b1;
			clk_en_ff   <= 1'b1;
			warm_ff     <= 1'b0;
			vreq_ff     <= 1'b0;
			vsel_ff     <= 1'b0;
			ale_ff      <= 1'b0;
			fetch_ff    <= 1'b0;
			p0_float_ff <= 1'b0;
			p2_addr_ff  <= 1'b0;
		end else begin
			osc_ff      <= nxt_mode != MODE_STOPPED;
			clk_en_ff   <= nxt_mode == MODE_RUN || nxt_mode == MODE_VECTOR;
			warm_ff     <= rst_lv;
			vreq_ff     <= nxt_mode == MODE_VECTOR;
			vsel_ff     <= nxt_src_irq;
			ale_ff      <= nxt_mode == MODE_IDLE ? 1'b1 :
				(nxt_mode == MODE_STOPPED || nxt_mode == MODE_WAKING) ? 1'b0 : core_ale;
			fetch_ff    <= nxt_mode == MODE_IDLE ? 1'b1 :
				(nxt_mode == MODE_STOPPED || nxt_mode == MODE_WAKING) ? 1'b0 :
				core_fetch_strobe;
			p0_float_ff <= ext_prog_mem && (nxt_mode == MODE_IDLE ||
				nxt_mode == MODE_STOPPED || nxt_mode == MODE_WAKING);
			p2_addr_ff  <= ext_prog_mem && nxt_mode == MODE_IDLE;
		end
	end

	assign s_axi_awready        = awready_ff;
	assign s_axi_wready         = wready_ff;
	assign s_axi_bvalid         = bvalid_ff;
	assign s_axi_bresp          = bresp_ff;
	assign s_axi_arready        = arready_ff;
	assign s_axi_rvalid         = rvalid_ff;
	assign s_axi_rdata          = rdata_ff;
	assign s_axi_rresp          = rresp_ff;
	assign osc_enable           = osc_ff;
	assign core_clk_en          = clk_en_ff;
	assign warm_reset           = warm_ff;
	assign wake_vector_req      = vreq_ff;
	assign wake_vector_sel      = vsel_ff;
	assign ale_out              = ale_ff;
	assign program_fetch_strobe = fetch_ff;
	assign port0_float          = p0_float_ff;
	assign port2_addr_sel       = p2_addr_ff;
	assign baud_double_select   = power_control_ff[BAUD_BIT];
	assign framing_error_select = power_control_ff[FRAME_BIT];
	assign irq                  = irq_ff;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_pd_enter;
		wr_power_control && wdata_ff[PD_BIT] && mode_ff == MODE_RUN && !rst_lv
			|=> mode_ff == MODE_STOPPED && !core_clk_en && power_control_ff[PD_BIT];
	endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

	property p_stopped_quiet;
		mode_ff == MODE_STOPPED |-> !osc_enable && !core_clk_en;
	endproperty
	a_stopped_quiet: assert property (p_stopped_quiet) else $error("clock runs in power-down");

	property p_strobes;
		(mode_ff == MODE_IDLE |-> ale_out && program_fetch_strobe) and
		(mode_ff == MODE_STOPPED |-> !ale_out && !program_fetch_strobe && !port2_addr_sel);
	endproperty
	a_strobes: assert property (p_strobes) else $error("strobe level wrong for mode");

	property p_no_stray_wake;
		mode_ff == MODE_STOPPED && !rst_lv && !w0 && !w1 |=> mode_ff == MODE_STOPPED;
	endproperty
	a_no_stray_wake: assert property (p_no_stray_wake) else $error("woke without cause");

	property p_clock_after_level;
		mode_ff == MODE_WAKING |-> !core_clk_en && osc_enable;
	endproperty
	a_clock_after_level: assert property (p_clock_after_level) else $error("early core clock");

	property p_vector_exit;
		mode_ff == MODE_VECTOR && vector_ack && !rst_lv
			|=> mode_ff == MODE_RUN && !power_control_ff[PD_BIT] && !wake_vector_req ##1 status_ff[EV_IRQ_WAKE];
	endproperty
	a_vector_exit: assert property (p_vector_exit) else $error("interrupt exit wrong");

	property p_warm_reset;
		rst_lv |=> power_control_ff[3:0] == 4'h0 && power_control_ff[7:5] == 3'h0 && warm_reset;
	endproperty
	a_warm_reset: assert property (p_warm_reset) else $error("warm reset left bits set");

	property p_cold_flag;
		!wr_power_control |=> power_control_ff[COLD_BIT] == $past(power_control_ff[COLD_BIT]);
	endproperty
	a_cold_flag: assert property (p_cold_flag) else $error("cold flag changed");

	property p_idle_exit;
		mode_ff == MODE_IDLE && irq_taken |=> !power_control_ff[SLEEP_BIT] && mode_ff == MODE_RUN;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not ended");

	property p_user_flags;
		wr_power_control && !rst_lv |=> power_control_ff[UF1_BIT:UF0_BIT] == $past(wdata_ff[3:2]);
	endproperty
	a_user_flags: assert property (p_user_flags) else $error("user flags not stored");
endmodule
`default_nettype wire

// [dv/core_model.sv]
// Core model: strobes while clocked, and the forced jump after an interrupt wake.
`default_nettype none
module core_model (
	// Clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Controller side.
	input  wire logic       core_clk_en,
	input  wire logic       wake_vector_req,
	input  wire logic [3:0] ack_delay,
	// Core outputs.
	output logic            vector_ack,
	output logic            core_ale,
	output logic            core_fetch_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_ff;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wait_ff <= 4'h0;
			vector_ack <= 1'b0;
			core_ale <= 1'b0;
			core_fetch_strobe <= 1'b1;
		end else begin
			// A stopped core cannot move its strobes, so they freeze with the gate.
			if (core_clk_en) begin
				core_ale <= ~core_ale;
				core_fetch_strobe <= core_ale;
			end
			vector_ack <= 1'b0;
			if (!wake_vector_req || vector_ack) begin
				wait_ff <= 4'h0;
			end else if (wait_ff == ack_delay) begin
				vector_ack <= 1'b1;
			end else begin
				wait_ff <= wait_ff + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/power_down_wake_control_bench.sv]
// Self-checking bench for the power-down and wake controller.
`default_nettype none
module power_down_wake_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pwr_pkg::*;
	logic sys_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, irq_prio, ack_delay;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, irq_enable, irq_level_mode, isr_prio, pin_n;
	logic core_ale, core_fetch_strobe, ext_prog_mem, isr_active, irq_taken, vector_ack;
	logic reset_pin, osc_enable, core_clk_en, warm_reset, wake_vector_req, wake_vector_sel;
	logic ale_out, program_fetch_strobe, port0_float, port2_addr_sel, irq;
	logic baud_double_select, framing_error_select;
	int err_count, checks_done, n;

	power_down_wake_control dut_u (.sys_clk(sys_clk), .reset(reset),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .core_ale(core_ale),
		.core_fetch_strobe(core_fetch_strobe), .ext_prog_mem(ext_prog_mem),
		.irq_enable(irq_enable), .irq_level_mode(irq_level_mode), .irq_prio(irq_prio),
		.isr_active(isr_active), .isr_prio(isr_prio), .irq_taken(irq_taken),
		.vector_ack(vector_ack), .ext_irq_zero_n(pin_n[0]), .ext_irq_one_n(pin_n[1]),
		.reset_pin(reset_pin), .osc_enable(osc_enable), .core_clk_en(core_clk_en),
		.warm_reset(warm_reset), .wake_vector_req(wake_vector_req),
		.wake_vector_sel(wake_vector_sel), .ale_out(ale_out),
		.program_fetch_strobe(program_fetch_strobe), .port0_float(port0_float),
		.port2_addr_sel(port2_addr_sel), .baud_double_select(baud_double_select),
		.framing_error_select(framing_error_select), .irq(irq));

	core_model partner_u (.sys_clk(sys_clk), .reset(reset), .core_clk_en(core_clk_en),
		.wake_vector_req(wake_vector_req), .ack_delay(ack_delay), .vector_ack(vector_ack),
		.core_ale(core_ale), .core_fetch_strobe(core_fetch_strobe));

	always #5 sys_clk = ~sys_clk;

	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		ck({31'h0, s_axi_bvalid}, 32'h00000001);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		ck({31'h0, s_axi_rvalid}, 32'h00000001);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rck(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		ck(rv, e);
	endtask

	task automatic cfg(input logic [1:0] m, input logic [1:0] e, input logic [3:0] p);
		@(posedge sys_clk);
		irq_level_mode <= m;
		irq_enable <= e;
		irq_prio <= p;
	endtask

	// A refused line is held low well past the filter delay; the oscillator must stay off.
	task automatic refused(input int ln);
		@(posedge sys_clk);
		pin_n[ln] <= 1'b0;
		repeat (10) @(posedge sys_clk);
		pin_n[ln] <= 1'b1;
		@(negedge sys_clk);
		ck({31'h00000000, osc_enable}, 32'h00000000);
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		$display("Error at %0t ns: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		err_count = 0;
		checks_done = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_prio, ack_delay} = 64'h0;
		{irq_enable, irq_level_mode, irq_taken, reset_pin} = 6'h00;
		{isr_active, isr_prio} = 3'h5;
		s_axi_wstrb = 4'hF;
		ext_prog_mem = 1'b1;
		pin_n = 2'h3;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		rck(POWER_CONTROL_ADDR, 32'h00000010);
		ck({30'h0, osc_enable, core_clk_en}, 32'h00000003);
		rd(12'h0F0);
		ck({30'h0, rr}, {30'h0, RESP_SLVERR});
		wr(12'h0F0, 8'hFF);
		ck({30'h0, rr}, {30'h0, RESP_SLVERR});
		wr(POWER_CONTROL_ADDR, 8'hEC);
		ck({30'h0, rr}, {30'h0, RESP_OKAY});
		rck(POWER_CONTROL_ADDR, 32'h000000CC);
		ck({30'h0, baud_double_select, framing_error_select}, 32'h00000003);
		wr(POWER_CONTROL_ADDR, 8'h1C);
		@(posedge sys_clk);
		reset_pin <= 1'b1;
		for (n = 0; n < 50 && warm_reset !== 1'b1; n++) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		reset_pin <= 1'b0;
		for (n = 0; n < 50 && warm_reset !== 1'b0; n++) @(posedge sys_clk);
		rck(POWER_CONTROL_ADDR, 32'h00000010);
		wr(INT_ENABLE_ADDR, 8'h0F);
		wr(INT_CLEAR_ADDR, 8'h0F);
		rck(INT_ENABLE_ADDR, 32'h0000000F);
		$display("Test registers done");
		wr(POWER_CONTROL_ADDR, 8'h11);
		@(negedge sys_clk);
		ck({28'h0, ale_out, program_fetch_strobe, port0_float, port2_addr_sel}, 32'hF);
		rd(MODE_STATUS_ADDR);
		ck({29'h0, rv[2:0]}, 32'h00000001);
		@(posedge sys_clk);
		irq_taken <= 1'b1;
		@(posedge sys_clk);
		irq_taken <= 1'b0;
		rck(POWER_CONTROL_ADDR, 32'h00000010);
		rck(INT_STATUS_ADDR, 32'h00000008);
		ck({31'h0, irq}, 32'h00000001);
		wr(INT_CLEAR_ADDR, 8'h0F);
		@(negedge sys_clk);
		ck({31'h0, irq}, 32'h00000000);
		$display("Test idle done");
		for (int ln = 0; ln < 2; ln++) begin
			ack_delay <= (ln == 0) ? 4'h0 : 4'h6;
			ext_prog_mem <= !ln[0];
			wr(POWER_CONTROL_ADDR, 8'h12);
			@(negedge sys_clk);
			ck({28'h0, osc_enable, core_clk_en, ale_out, program_fetch_strobe}, 32'h0);
			ck({30'h0, port0_float, port2_addr_sel}, {30'h0, !ln[0], 1'b0});
			cfg(2'h0, 2'h3, 4'hA);
			refused(ln);
			cfg(2'h3, 2'h0, 4'hA);
			refused(ln);
			cfg(2'h3, 2'h3, 4'h5);
			refused(ln);
			cfg(2'h3, 2'h3, 4'hA);
			pin_n[ln] <= 1'b0;
			for (n = 0; n < 50 && osc_enable !== 1'b1; n++) @(posedge sys_clk);
			repeat (5) @(posedge sys_clk);
			@(negedge sys_clk);
			ck({30'h0, osc_enable, core_clk_en}, 32'h00000002);
			@(posedge sys_clk);
			pin_n[ln] <= 1'b1;
			for (n = 0; n < 50 && wake_vector_req !== 1'b1; n++) @(posedge sys_clk);
			@(negedge sys_clk);
			ck({30'h0, core_clk_en, wake_vector_sel}, {30'h0, 1'b1, ln[0]});
			for (n = 0; n < 50 && wake_vector_req !== 1'b0; n++) @(posedge sys_clk);
			rck(POWER_CONTROL_ADDR, 32'h00000010);
			rck(INT_STATUS_ADDR, 32'h00000003);
			wr(INT_CLEAR_ADDR, 8'h0F);
		end
		$display("Test interrupt wake done");
		wr(POWER_CONTROL_ADDR, 8'h1E);
		@(posedge sys_clk);
		reset_pin <= 1'b1;
		for (n = 0; n < 50 && osc_enable !== 1'b1; n++) @(posedge sys_clk);
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		ck({30'h0, core_clk_en, warm_reset}, 32'h00000001);
		@(posedge sys_clk);
		reset_pin <= 1'b0;
		for (n = 0; n < 50 && core_clk_en !== 1'b1; n++) @(posedge sys_clk);
		rck(POWER_CONTROL_ADDR, 32'h00000010);
		rck(INT_STATUS_ADDR, 32'h00000005);
		$display("Test reset wake done");
		wrap_up();
	end
endmodule
`default_nettype wire
